// ### verification/rhbl_boot_loader_tb.sv
// self-checking bench for the reset and host boot loader
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fails++; $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
module rhbl_boot_loader_tb;
	typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} rhbl_row_t;
	logic clk, reset_n, ext_n, boot_pad, bite, wd_en, dbg_en, vpass, vfail, fifo_rd;
	logic [7:0] addr, wdata, rdata, irq_cfg, link_cfg;
	logic wr, img_valid, img_last, ev_wake, ev_nonwake, core_rst_n, dbg_rst_n;
	logic host_mode, flash_start, turbo_off, host_irq;
	logic [31:0] img_word;
	logic [31:0] got_words[$];
	logic got_last;
	int fails = 0;
	int num_checks = 0;
	int core_falls = 0;
	int dbg_falls = 0;
	int flash_starts = 0;
	int inits = 0;
	int split_inits = 0;
	// identity values are arbitrary
	rhbl_row_t rows [9] = '{'{8'h05, 8'h01, 8'h01}, '{8'h07, 8'h5A, 8'h5A}, '{8'h16, 8'h3C, 8'h3C},
		'{8'h1C, 8'hFF, 8'hA5}, '{8'h1D, 8'hFF, 8'h11}, '{8'h1E, 8'hFF, 8'h34}, '{8'h1F, 8'hFF, 8'h12},
		'{8'h30, 8'h77, 8'h00}, '{8'h00, 8'h00, 8'h00}};

	rhbl_boot_loader #(.LOADER_CYCLES(20), .IMAGE_CYCLES(20)) dut (.i_clk(clk), .i_reset_n(reset_n),
		.i_external_reset_pad_n(ext_n),
		.i_boot_select_pad(boot_pad), .i_watchdog_bite(bite), .i_watchdog_enable(wd_en),
		.i_debug_port_enable(dbg_en), .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_wdata(wdata),
		.o_reg_rdata(rdata), .o_image_valid(img_valid), .o_image_word(img_word), .o_image_last(img_last),
		.i_verify_pass(vpass), .i_verify_fail(vfail), .i_fifo_read(fifo_rd), .o_init_event_wake(ev_wake),
		.o_init_event_nonwake(ev_nonwake), .o_core_reset_n(core_rst_n), .o_debug_reset_n(dbg_rst_n),
		.o_host_load_mode(host_mode), .o_flash_boot_start(flash_start), .o_core_turbo_off(turbo_off),
		.o_irq_config(irq_cfg), .o_link_config(link_cfg), .o_host_irq(host_irq));
	rhbl_host_model host (.i_clk(clk), .i_reg_rdata(rdata), .o_reg_addr(addr), .o_reg_wr(wr),
		.o_reg_wdata(wdata));

	////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(negedge core_rst_n) core_falls++;
	always @(negedge dbg_rst_n) dbg_falls++;
	always @(posedge clk) begin
		if (img_valid === 1'b1) begin
			got_words.push_back(img_word);
			got_last = img_last;
		end
		if (flash_start === 1'b1) flash_starts++;
		if (ev_wake === 1'b1) inits++;
		if (ev_wake !== ev_nonwake) split_inits++;
	end

	task automatic finish_test();
		$display("checks %0d errors %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// levels settle one cycle before the bite
	task automatic bite_with(input logic en, input logic dbg);
		@(negedge clk);
		wd_en = en;
		dbg_en = dbg;
		@(negedge clk);
		bite = 1'b1;
		@(negedge clk);
		bite = 1'b0;
		repeat (3) @(negedge clk);
	endtask
	task automatic pulse_verdict(input logic fail);
		@(negedge clk);
		vfail = fail;
		vpass = ~fail;
		@(negedge clk);
		vfail = 1'b0;
		vpass = 1'b0;
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		finish_test();
	end

	initial begin : main
		logic [7:0] v;
		logic seen;
		reset_n = 1'b0;
		ext_n = 1'b1;
		boot_pad = 1'b0;
		{bite, wd_en, dbg_en, vpass, vfail, fifo_rd} = 6'h00;
		repeat (20) @(negedge clk);
		`CHK(core_rst_n, 1'b0)
		`CHK(dbg_rst_n, 1'b0)
		reset_n = 1'b1;
		repeat (80) @(negedge clk);
		`CHK(host_mode, 1'b0)
		`CHK(flash_starts, 1)
		host.rd_reg(rhbl_pkg::OFS_SPEED_CTRL, v);
		`CHK(v, rhbl_pkg::RST_SPEED_CTRL)
		host.rd_reg(rhbl_pkg::OFS_IRQ_CONFIG, v);
		`CHK(v, rhbl_pkg::RST_IRQ_CONFIG)
		host.rd_reg(rhbl_pkg::OFS_LINK_CONFIG, v);
		`CHK(v, rhbl_pkg::RST_LINK_CONFIG)
		// register rows: write all but the command channel, then read back; identity rows are read-only, 0x30 reads zero
		for (int i = 0; i < 9; i++) begin
			if (rows[i].a != rhbl_pkg::OFS_CMD_CHANNEL) host.wr_reg(rows[i].a, rows[i].d);
			host.rd_reg(rows[i].a, v);
			`CHK(v, rows[i].e)
		end
		`CHK(turbo_off, 1'b1)
		`CHK(irq_cfg, 8'h5A)
		`CHK(link_cfg, 8'h3C)
		// wrong value to the soft reset register
		core_falls = 0;
		host.wr_reg(rhbl_pkg::OFS_SOFT_RESET, 8'h02);
		repeat (3) @(negedge clk);
		`CHK(core_falls, 0)
		dbg_falls = 0;
		host.wr_reg(rhbl_pkg::OFS_SOFT_RESET, rhbl_pkg::SOFT_RESET_VALUE);
		`CHK(irq_cfg, 8'h5A)
		// link config first, then interrupt config
		host.wr_reg(rhbl_pkg::OFS_LINK_CONFIG, 8'hC3);
		host.wr_reg(rhbl_pkg::OFS_IRQ_CONFIG, 8'h6B);
		host.wait_flag(rhbl_pkg::FLAG_IFACE_READY_BIT, 200, seen);
		`CHK(core_falls, 1)
		`CHK(dbg_falls, 0)
		`CHK(host_mode, 1'b1)
		`CHK(seen, 1'b1)
		`CHK(irq_cfg, 8'h6B)
		`CHK(link_cfg, 8'hC3)
		// slow host, two-word image
		host.gap = 2;
		host.send_cmd(rhbl_pkg::CMD_IMAGE_UPLOAD, 16'h0002);
		host.send_word(32'h44332211);
		host.send_word(32'h88776655);
		host.gap = 0;
		repeat (4) @(negedge clk);
		`CHK(got_words.size(), 2)
		`CHK(got_words[0], 32'h44332211)
		`CHK(got_words[1], 32'h88776655)
		`CHK(got_last, 1'b1)
		// early launch is ignored
		host.send_cmd(rhbl_pkg::CMD_IMAGE_LAUNCH, 16'h0000);
		repeat (4) @(negedge clk);
		host.rd_reg(rhbl_pkg::OFS_BOOT_FLAGS, v);
		`CHK(v[rhbl_pkg::FLAG_IFACE_READY_BIT], 1'b1)
		pulse_verdict(1'b1);
		host.rd_reg(rhbl_pkg::OFS_BOOT_FLAGS, v);
		`CHK({v[rhbl_pkg::FLAG_VERIFY_ERR_BIT], v[rhbl_pkg::FLAG_VERIFY_DONE_BIT]}, 2'b10)
		// retry after the error
		got_words.delete();
		host.send_cmd(rhbl_pkg::CMD_IMAGE_UPLOAD, 16'h0001);
		host.rd_reg(rhbl_pkg::OFS_BOOT_FLAGS, v);
		`CHK({v[rhbl_pkg::FLAG_VERIFY_ERR_BIT], v[rhbl_pkg::FLAG_VERIFY_DONE_BIT]}, 2'b00)
		host.send_word(32'hCAFE0001);
		repeat (4) @(negedge clk);
		`CHK(got_words.size(), 1)
		pulse_verdict(1'b0);
		host.wait_flag(rhbl_pkg::FLAG_VERIFY_DONE_BIT, 10, seen);
		`CHK(seen, 1'b1)
		inits = 0;
		split_inits = 0;
		host.send_cmd(rhbl_pkg::CMD_IMAGE_LAUNCH, 16'h0000);
		repeat (2) @(negedge clk);
		host.rd_reg(rhbl_pkg::OFS_BOOT_FLAGS, v);
		`CHK(v[rhbl_pkg::FLAG_IFACE_READY_BIT], 1'b0)
		host.wait_flag(rhbl_pkg::FLAG_IFACE_READY_BIT, 100, seen);
		`CHK(seen, 1'b1)
		`CHK(inits, 1)
		`CHK(split_inits, 0)
		`CHK(host_irq, 1'b1)
		@(negedge clk);
		fifo_rd = 1'b1;
		@(negedge clk);
		fifo_rd = 1'b0;
		`CHK(host_irq, 1'b0)
		// suppressed bites, then a real one with the pad low
		core_falls = 0;
		bite_with(1'b0, 1'b0);
		bite_with(1'b1, 1'b1);
		`CHK(core_falls, 0)
		dbg_falls = 0;
		flash_starts = 0;
		bite_with(1'b1, 1'b0);
		repeat (80) @(negedge clk);
		`CHK(core_falls, 1)
		`CHK(dbg_falls, 0)
		`CHK(flash_starts, 1)
		`CHK(host_mode, 1'b0)
		// external pad with the boot pad high
		boot_pad = 1'b1;
		ext_n = 1'b0;
		repeat (6) @(negedge clk);
		`CHK(core_rst_n, 1'b0)
		`CHK(dbg_rst_n, 1'b0)
		ext_n = 1'b1;
		host.wait_flag(rhbl_pkg::FLAG_IFACE_READY_BIT, 200, seen);
		`CHK(seen, 1'b1)
		`CHK(host_mode, 1'b1)
		finish_test();
	end
endmodule // rhbl_boot_loader_tb

// ### verification/rhbl_host_model.sv
// host processor model on the byte register port
`timescale 1ns/1ps
module rhbl_host_model (
	// clock
	input wire logic i_clk,
	// register port
	input wire logic [7:0] i_reg_rdata,
	output logic [7:0] o_reg_addr,
	output logic o_reg_wr,
	output logic [7:0] o_reg_wdata
);
	// idle cycles after each byte, raised to act as a slow host
	int gap = 0;
	initial begin
		o_reg_addr = rhbl_pkg::OFS_BOOT_FLAGS;
		o_reg_wr = 1'b0;
		o_reg_wdata = 8'h00;
	end
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(negedge i_clk);
		o_reg_addr = a;
		o_reg_wdata = d;
		o_reg_wr = 1'b1;
		@(negedge i_clk);
		o_reg_wr = 1'b0;
		// data is stale once taken
		o_reg_wdata = ~d;
		repeat (gap) @(negedge i_clk);
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(negedge i_clk);
		o_reg_addr = a;
		#1 d = i_reg_rdata;
	endtask
	// whole four-byte units, lowest byte first
	task automatic send_word(input logic [31:0] w);
		for (int i = 0; i < 4; i++) begin
			wr_reg(rhbl_pkg::OFS_CMD_CHANNEL, w[8*i +: 8]);
		end
	endtask
	// header sent once, length in words of the whole image
	task automatic send_cmd(input logic [15:0] code, input logic [15:0] words);
		send_word({words, code});
	endtask
	// bounded poll of one boot flag
	task automatic wait_flag(input int pos, input int max, output logic seen);
		logic [7:0] v;
		seen = 1'b0;
		for (int n = 0; n < max && seen !== 1'b1; n++) begin
			rd_reg(rhbl_pkg::OFS_BOOT_FLAGS, v);
			seen = v[pos];
		end
	endtask
endmodule // rhbl_host_model

// ### verilog/rhbl_boot_loader.sv
// reset sources, boot mode selection and host image upload handshake
// Notes on behaviour
// R1: four reset sources; power-on and external pad reset everything. Pad reset here keeps speed, interrupt and link config.
// R2: host and watchdog resets spare the debug port.
// R3: watchdog reset suppressed when watchdog off or debug port on.
// R4: writing one to soft reset register triggers a host reset.
// R5: after any reset the loader starts from its beginning.
// R6: host-load mode if boot pad high or last reset was host reset.
// R7: in host-load mode set interface-ready after loader start-up.
// R8: host may write link config, then interrupt config.
// R9: turbo-disable bit selects 20 MHz, clear selects 50 MHz.
// R10: host polls ready flag or waits start-up time before upload.
// R11: host may read product, revision and ROM version first.
// R12: upload starts with command 0x0002, writes in whole words.
// R13: only the first transaction carries the upload header.
// R14: upload length field counts 32-bit words of the image.
// R15: verify during load; set verify-done or verify-error flag.
// R16: host polls verify flags and recovers on error.
// R17: launch is command 0x0003 on the command channel.
// R18: launch clears the interface-ready flag.
// R19: after boot set ready, insert init events, raise host interrupt.
// R20: host reads fifo to clear the first interrupt.
// R21: header is command code then length, each two bytes LSB first.
// R22: commands padded to four bytes, padding counted in length.
// R23: launch before verify-done is ignored, ready unchanged.
`timescale 1ns/1ps
module rhbl_boot_loader #(
	parameter int unsigned LOADER_CYCLES = rhbl_pkg::LOADER_STARTUP_CYC,
	parameter int unsigned IMAGE_CYCLES = rhbl_pkg::IMAGE_STARTUP_CYC,
	// identity values are arbitrary
	parameter logic [7:0] PRODUCT_CODE = 8'hA5,
	parameter logic [7:0] REVISION_CODE = 8'h11,
	parameter logic [15:0] ROM_VERSION = 16'h1234
) (
	// clock and power-on reset
	input wire logic i_clk,
	input wire logic i_reset_n,
	// pads
	input wire logic i_external_reset_pad_n,
	input wire logic i_boot_select_pad,
	// watchdog and debug port
	input wire logic i_watchdog_bite,
	input wire logic i_watchdog_enable,
	input wire logic i_debug_port_enable,
	// host byte register port
	input wire logic [7:0] i_reg_addr,
	input wire logic i_reg_wr,
	input wire logic [7:0] i_reg_wdata,
	output logic [7:0] o_reg_rdata,
	// image verifier
	output logic o_image_valid,
	output logic [31:0] o_image_word,
	output logic o_image_last,
	input wire logic i_verify_pass,
	input wire logic i_verify_fail,
	// fifo side
	input wire logic i_fifo_read,
	output logic o_init_event_wake,
	output logic o_init_event_nonwake,
	// resets, mode and config outputs
	output logic o_core_reset_n,
	output logic o_debug_reset_n,
	output logic o_host_load_mode,
	output logic o_flash_boot_start,
	output logic o_core_turbo_off,
	output logic [7:0] o_irq_config,
	output logic [7:0] o_link_config,
	output logic o_host_irq
);

	////////////////////////////////////////////////////////////////////////
	// pad synchronisers and reset sources

	logic ext_pad_n_s;
	logic boot_pad_s;

	// idle level of the pad, so power-on does not look like a pad reset
	rhbl_sync2 #(.RESET_LEVEL(1'b1)) u_sync_ext (
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.i_async(i_external_reset_pad_n),
		.o_sync(ext_pad_n_s)
	);

	rhbl_sync2 #(.RESET_LEVEL(1'b0)) u_sync_boot (
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.i_async(i_boot_select_pad),
		.o_sync(boot_pad_s)
	);

	wire ext_reset = !ext_pad_n_s;
	wire host_reset = i_reg_wr && (i_reg_addr == rhbl_pkg::OFS_SOFT_RESET) &&
		(i_reg_wdata == rhbl_pkg::SOFT_RESET_VALUE); // R4
	wire wdog_reset = i_watchdog_bite && i_watchdog_enable && !i_debug_port_enable; // R3
	wire any_reset = ext_reset || host_reset || wdog_reset; // R1

	rhbl_pkg::rhbl_cause_t cause_q;
	logic [4:0] hold_cnt_q;
	logic debug_rst_n_q;
	logic core_rst_n_q;

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			cause_q <= rhbl_pkg::RHBL_CAUSE_POR;
			hold_cnt_q <= rhbl_pkg::CORE_RESET_CYC;
			core_rst_n_q <= 1'b0; // R1
			debug_rst_n_q <= 1'b0; // R1
		end else begin
			// the debug port follows only the hard sources
			debug_rst_n_q <= !ext_reset; // R2
			if (any_reset) begin
				hold_cnt_q <= rhbl_pkg::CORE_RESET_CYC;
				core_rst_n_q <= 1'b0;
			end else if (hold_cnt_q != 5'h00) begin
				hold_cnt_q <= hold_cnt_q - 5'h01;
			end else begin
				core_rst_n_q <= 1'b1;
			end
			// external reset outranks softer sources in the cause record
			if (ext_reset) begin
				cause_q <= rhbl_pkg::RHBL_CAUSE_EXT;
			end else if (host_reset) begin
				cause_q <= rhbl_pkg::RHBL_CAUSE_HOST;
			end else if (wdog_reset) begin
				cause_q <= rhbl_pkg::RHBL_CAUSE_WDOG;
			end
		end
	end

	assign o_core_reset_n = core_rst_n_q;
	assign o_debug_reset_n = debug_rst_n_q;

	////////////////////////////////////////////////////////////////////////
	// host registers

	logic [7:0] speed_q;
	logic [7:0] irq_cfg_q;
	logic [7:0] link_cfg_q;

	wire wr_speed = i_reg_wr && (i_reg_addr == rhbl_pkg::OFS_SPEED_CTRL);
	wire wr_irq = i_reg_wr && (i_reg_addr == rhbl_pkg::OFS_IRQ_CONFIG);
	wire wr_link = i_reg_wr && (i_reg_addr == rhbl_pkg::OFS_LINK_CONFIG);
	wire wr_cmd = i_reg_wr && (i_reg_addr == rhbl_pkg::OFS_CMD_CHANNEL);

	// host-side configuration lives in the interface and survives soft resets
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			speed_q <= rhbl_pkg::RST_SPEED_CTRL;
			irq_cfg_q <= rhbl_pkg::RST_IRQ_CONFIG;
			link_cfg_q <= rhbl_pkg::RST_LINK_CONFIG;
		end else begin
			if (wr_speed) begin
				speed_q <= i_reg_wdata; // R9
			end
			if (wr_irq) begin
				irq_cfg_q <= i_reg_wdata;
			end
			if (wr_link) begin
				link_cfg_q <= i_reg_wdata;
			end
		end
	end

	assign o_core_turbo_off = speed_q[rhbl_pkg::SPEED_TURBO_OFF_BIT]; // R9
	assign o_irq_config = irq_cfg_q;
	assign o_link_config = link_cfg_q;

	////////////////////////////////////////////////////////////////////////
	// command channel word assembly

	logic word_valid;
	logic [31:0] word;
	rhbl_pkg::rhbl_state_t state_q;

	rhbl_word_packer u_packer (
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.i_clear(!core_rst_n_q),
		.i_byte_valid(wr_cmd),
		.i_byte(i_reg_wdata),
		.o_word_valid(word_valid),
		.o_word(word)
	);

	// header: code in the low half, length in the high half
	wire [15:0] hdr_code = word[15:0]; // R21
	wire [15:0] hdr_len = word[31:16]; // R21
	wire hdr_slot = (state_q == rhbl_pkg::RHBL_READY) || (state_q == rhbl_pkg::RHBL_LOADED) ||
		(state_q == rhbl_pkg::RHBL_VERIFY);
	wire cmd_upload = word_valid && hdr_slot && (hdr_code == rhbl_pkg::CMD_IMAGE_UPLOAD); // R12
	wire cmd_launch = word_valid && hdr_slot && (hdr_code == rhbl_pkg::CMD_IMAGE_LAUNCH); // R17
	wire data_word = word_valid && (state_q == rhbl_pkg::RHBL_UPLOAD); // R13

	////////////////////////////////////////////////////////////////////////
	// boot sequence

	logic [19:0] wait_q;
	logic [15:0] words_left_q;
	logic ready_q;
	logic done_q;
	logic err_q;
	logic host_mode_q;
	logic irq_q;
	logic init_ev_q;
	logic flash_q;
	logic img_valid_q;
	logic img_last_q;
	logic [31:0] img_word_q;

	wire wait_over = (wait_q == 20'h00000);
	wire host_mode_d = boot_pad_s || (cause_q == rhbl_pkg::RHBL_CAUSE_HOST); // R6
	wire launch_ok = cmd_launch && done_q; // R23

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state_q <= rhbl_pkg::RHBL_HOLD;
			wait_q <= 20'h00000;
			words_left_q <= 16'h0000;
			host_mode_q <= 1'b0;
			flash_q <= 1'b0;
			init_ev_q <= 1'b0;
			img_valid_q <= 1'b0;
			img_last_q <= 1'b0;
			img_word_q <= 32'h0000_0000;
		end else if (!core_rst_n_q) begin
			state_q <= rhbl_pkg::RHBL_HOLD; // R5
			flash_q <= 1'b0;
			init_ev_q <= 1'b0;
			img_valid_q <= 1'b0;
			img_last_q <= 1'b0;
		end else begin
			flash_q <= 1'b0;
			init_ev_q <= 1'b0;
			img_valid_q <= data_word;
			img_last_q <= data_word && (words_left_q == 16'h0001);
			if (data_word) begin
				img_word_q <= word;
			end
			unique case (state_q)
				rhbl_pkg::RHBL_HOLD: begin
					host_mode_q <= host_mode_d; // R6
					wait_q <= 20'(LOADER_CYCLES);
					state_q <= rhbl_pkg::RHBL_INIT; // R5
				end
				rhbl_pkg::RHBL_INIT: begin
					if (!wait_over) begin
						wait_q <= wait_q - 20'h00001;
					end else if (host_mode_q) begin
						state_q <= rhbl_pkg::RHBL_READY; // R7
					end else begin
						flash_q <= 1'b1;
						state_q <= rhbl_pkg::RHBL_FLASH;
					end
				end
				rhbl_pkg::RHBL_READY, rhbl_pkg::RHBL_VERIFY, rhbl_pkg::RHBL_LOADED: begin
					if (cmd_upload && (hdr_len != 16'h0000)) begin
						words_left_q <= hdr_len; // R14
						state_q <= rhbl_pkg::RHBL_UPLOAD;
					end else if (launch_ok) begin
						wait_q <= 20'(IMAGE_CYCLES);
						state_q <= rhbl_pkg::RHBL_BOOTING;
					end else if (done_q && state_q == rhbl_pkg::RHBL_VERIFY) begin
						state_q <= rhbl_pkg::RHBL_LOADED;
					end
				end
				rhbl_pkg::RHBL_UPLOAD: begin
					if (data_word) begin
						words_left_q <= words_left_q - 16'h0001; // R14
						if (words_left_q == 16'h0001) begin
							state_q <= rhbl_pkg::RHBL_VERIFY;
						end
					end
				end
				rhbl_pkg::RHBL_BOOTING: begin
					if (!wait_over) begin
						wait_q <= wait_q - 20'h00001;
					end else begin
						init_ev_q <= 1'b1; // R19
						state_q <= rhbl_pkg::RHBL_RUN;
					end
				end
				rhbl_pkg::RHBL_RUN, rhbl_pkg::RHBL_FLASH: begin
					state_q <= state_q;
				end
				default: begin
					state_q <= rhbl_pkg::RHBL_HOLD;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// status flags and host interrupt

	wire ready_set = (state_q == rhbl_pkg::RHBL_INIT) && wait_over && host_mode_q; // R7
	wire ready_clr = launch_ok && (state_q != rhbl_pkg::RHBL_UPLOAD); // R18
	wire verify_active = (state_q == rhbl_pkg::RHBL_UPLOAD) || (state_q == rhbl_pkg::RHBL_VERIFY);
	wire verify_clr = cmd_upload;

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ready_q <= 1'b0;
			done_q <= 1'b0;
			err_q <= 1'b0;
			irq_q <= 1'b0;
		end else if (!core_rst_n_q) begin
			ready_q <= 1'b0;
			done_q <= 1'b0;
			err_q <= 1'b0;
			irq_q <= 1'b0;
		end else begin
			if (ready_set || init_ev_q) begin
				ready_q <= 1'b1; // R19
			end else if (ready_clr) begin
				ready_q <= 1'b0; // R18
			end
			// a verdict landing with a new upload header still counts
			if (verify_active && i_verify_pass && !i_verify_fail) begin
				done_q <= 1'b1; // R15
			end else if (verify_clr) begin
				done_q <= 1'b0;
			end
			if (verify_active && i_verify_fail) begin
				err_q <= 1'b1; // R15
			end else if (verify_clr) begin
				err_q <= 1'b0;
			end
			if (init_ev_q) begin
				irq_q <= 1'b1; // R19
			end else if (i_fifo_read) begin
				irq_q <= 1'b0; // R20
			end
		end
	end

	assign o_host_irq = irq_q;
	assign o_init_event_wake = init_ev_q;
	assign o_init_event_nonwake = init_ev_q;
	assign o_host_load_mode = host_mode_q;
	assign o_flash_boot_start = flash_q;
	assign o_image_valid = img_valid_q;
	assign o_image_last = img_last_q;
	assign o_image_word = img_word_q;

	////////////////////////////////////////////////////////////////////////
	// read data

	wire [7:0] flags = (8'(ready_q) << rhbl_pkg::FLAG_IFACE_READY_BIT) |
		(8'(done_q) << rhbl_pkg::FLAG_VERIFY_DONE_BIT) |
		(8'(err_q) << rhbl_pkg::FLAG_VERIFY_ERR_BIT);

	assign o_reg_rdata =
		(i_reg_addr == rhbl_pkg::OFS_SPEED_CTRL) ? speed_q :
		(i_reg_addr == rhbl_pkg::OFS_IRQ_CONFIG) ? irq_cfg_q :
		(i_reg_addr == rhbl_pkg::OFS_LINK_CONFIG) ? link_cfg_q :
		(i_reg_addr == rhbl_pkg::OFS_PRODUCT) ? PRODUCT_CODE :
		(i_reg_addr == rhbl_pkg::OFS_REVISION) ? REVISION_CODE :
		(i_reg_addr == rhbl_pkg::OFS_ROM_VER_LO) ? ROM_VERSION[7:0] :
		(i_reg_addr == rhbl_pkg::OFS_ROM_VER_HI) ? ROM_VERSION[15:8] :
		(i_reg_addr == rhbl_pkg::OFS_BOOT_FLAGS) ? flags : 8'h00;

	////////////////////////////////////////////////////////////////////////
	// checks

	a_soft_reset_hold: assert property (@(posedge i_clk) disable iff (!i_reset_n) // R4
		host_reset |=> !o_core_reset_n [*8])
		else $error("soft reset did not hold the core in reset");

	a_hard_reset_debug: assert property (@(posedge i_clk) disable iff (!i_reset_n) // R1
		ext_reset |=> !o_debug_reset_n && !o_core_reset_n)
		else $error("external reset missed a block");

	a_debug_kept: assert property (@(posedge i_clk) disable iff (!i_reset_n) // R2
		(host_reset || wdog_reset) && !ext_reset && o_debug_reset_n |=> o_debug_reset_n)
		else $error("soft reset disturbed the debug port");

	a_wdog_suppressed: assert property (@(posedge i_clk) disable iff (!i_reset_n) // R3
		i_watchdog_bite && i_debug_port_enable && !ext_reset && !host_reset &&
		o_core_reset_n && hold_cnt_q == 5'h00 |=> o_core_reset_n)
		else $error("suppressed watchdog still reset the core");

	a_mode_select: assert property (@(posedge i_clk) disable iff (!i_reset_n) // R6
		state_q == rhbl_pkg::RHBL_HOLD && core_rst_n_q |=> o_host_load_mode == $past(host_mode_d))
		else $error("boot mode wrongly chosen");

	a_ready_after_init: assert property (@(posedge i_clk) disable iff (!i_reset_n) // R7
		ready_set && !any_reset |=> ##1 flags[rhbl_pkg::FLAG_IFACE_READY_BIT])
		else $error("ready flag not set after loader start-up");

	a_launch_clears: assert property (@(posedge i_clk) disable iff (!i_reset_n) // R18
		launch_ok && core_rst_n_q && !any_reset |=> !ready_q && state_q == rhbl_pkg::RHBL_BOOTING)
		else $error("launch did not clear the ready flag");

	a_early_launch: assert property (@(posedge i_clk) disable iff (!i_reset_n) // R23
		cmd_launch && !done_q && !cmd_upload && core_rst_n_q && !any_reset |=> $stable(ready_q))
		else $error("launch before verify-done was acted on");

	a_boot_complete: assert property (@(posedge i_clk) disable iff (!i_reset_n) // R19
		init_ev_q && core_rst_n_q |=> ready_q && o_host_irq)
		else $error("boot completion not signalled");

	a_turbo_bit: assert property (@(posedge i_clk) disable iff (!i_reset_n) // R9
		wr_speed |=> o_core_turbo_off == $past(i_reg_wdata[0]))
		else $error("turbo-disable bit not applied");

	a_verify_flag: assert property (@(posedge i_clk) disable iff (!i_reset_n) // R15
		verify_active && i_verify_fail && core_rst_n_q |=> err_q ##1 err_q || !core_rst_n_q)
		else $error("verify error flag not raised");

endmodule // rhbl_boot_loader

// ### verilog/rhbl_pkg.sv
// constants for the reset and host boot loader block
package rhbl_pkg;

	// clock
	localparam int unsigned CLK_MHZ = 10;

	// register offsets on the host byte register port
	localparam logic [7:0] OFS_CMD_CHANNEL = 8'h00;
	localparam logic [7:0] OFS_SPEED_CTRL = 8'h05;
	localparam logic [7:0] OFS_IRQ_CONFIG = 8'h07;
	localparam logic [7:0] OFS_SOFT_RESET = 8'h14;
	localparam logic [7:0] OFS_LINK_CONFIG = 8'h16;
	localparam logic [7:0] OFS_PRODUCT = 8'h1C;
	localparam logic [7:0] OFS_REVISION = 8'h1D;
	localparam logic [7:0] OFS_ROM_VER_LO = 8'h1E;
	localparam logic [7:0] OFS_ROM_VER_HI = 8'h1F;
	localparam logic [7:0] OFS_BOOT_FLAGS = 8'h25;

	// reset values
	localparam logic [7:0] RST_SPEED_CTRL = 8'h00;
	localparam logic [7:0] RST_IRQ_CONFIG = 8'h00;
	localparam logic [7:0] RST_LINK_CONFIG = 8'h00;

	// field positions and the soft reset value
	localparam int unsigned SPEED_TURBO_OFF_BIT = 0;
	localparam logic [7:0] SOFT_RESET_VALUE = 8'h01;
	localparam int unsigned FLAG_IFACE_READY_BIT = 4;
	localparam int unsigned FLAG_VERIFY_DONE_BIT = 5;
	localparam int unsigned FLAG_VERIFY_ERR_BIT = 6;

	// command codes
	localparam logic [15:0] CMD_IMAGE_UPLOAD = 16'h0002;
	localparam logic [15:0] CMD_IMAGE_LAUNCH = 16'h0003;

	// timing: printed figures in microseconds, cycles derived
	localparam int unsigned LOADER_STARTUP_US = 1000;
	localparam int unsigned IMAGE_STARTUP_US = 2000;
	localparam int unsigned LOADER_STARTUP_CYC = LOADER_STARTUP_US * CLK_MHZ;
	localparam int unsigned IMAGE_STARTUP_CYC = IMAGE_STARTUP_US * CLK_MHZ;
	localparam logic [4:0] CORE_RESET_CYC = 5'h10;

	// boot sequence states
	typedef enum logic [3:0] {
		RHBL_HOLD,
		RHBL_INIT,
		RHBL_READY,
		RHBL_UPLOAD,
		RHBL_VERIFY,
		RHBL_LOADED,
		RHBL_BOOTING,
		RHBL_RUN,
		RHBL_FLASH
	} rhbl_state_t;

	// cause of the last reset
	typedef enum logic [1:0] {
		RHBL_CAUSE_POR,
		RHBL_CAUSE_EXT,
		RHBL_CAUSE_HOST,
		RHBL_CAUSE_WDOG
	} rhbl_cause_t;

endpackage

// ### verilog/rhbl_sync2.sv
// two flip-flop synchroniser for pad levels
`timescale 1ns/1ps
module rhbl_sync2 #(
	parameter logic RESET_LEVEL = 1'b0
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_reset_n,
	// pad level in, synchronised level out
	input wire logic i_async,
	output logic o_sync
);

	logic meta_q;
	logic sync_q;

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			meta_q <= RESET_LEVEL;
			sync_q <= RESET_LEVEL;
		end else begin
			meta_q <= i_async;
			sync_q <= meta_q;
		end
	end

	assign o_sync = sync_q;

endmodule // rhbl_sync2

// ### verilog/rhbl_word_packer.sv
// packs command channel bytes into 32-bit words, lowest byte first
`timescale 1ns/1ps
module rhbl_word_packer (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_reset_n,
	// byte stream
	input wire logic i_clear,
	input wire logic i_byte_valid,
	input wire logic [7:0] i_byte,
	// word stream
	output logic o_word_valid,
	output logic [31:0] o_word
);

	logic [1:0] idx_q;
	logic [31:0] word_q;
	logic valid_q;

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			idx_q <= 2'h0;
			word_q <= 32'h0000_0000;
			valid_q <= 1'b0;
		end else begin
			valid_q <= i_byte_valid && (idx_q == 2'h3) && !i_clear;
			if (i_clear) begin
				idx_q <= 2'h0;
			end else if (i_byte_valid) begin
				word_q[idx_q*8 +: 8] <= i_byte;
				idx_q <= idx_q + 2'h1;
			end
		end
	end

	assign o_word_valid = valid_q;
	assign o_word = word_q;

endmodule // rhbl_word_packer
